//--- inc/i2cm_pkg.sv
package i2cm_pkg;
  // register byte addresses on the bus
  localparam logic [7:0] ADDR_CTRL2 = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_DATA = 8'h08;
  localparam logic [7:0] ADDR_BAUD = 8'h0C;
  localparam logic [7:0] ADDR_FLAG = 8'h10;
  // serial_control_two fields
  localparam int B_START = 0;
  localparam int B_STOP = 2;
  localparam int B_RECV = 3;
  localparam int B_ACK_SEQUENCE_ENABLE = 4;
  localparam int B_ACK_DATA_VALUE = 5;
  localparam int B_ACKST = 6;
  // serial_status_register fields
  localparam int S_BF = 0;
  localparam int S_START = 3;
  localparam int S_STOPD = 4;
  // event flag register fields, write one to clear
  localparam int F_SIF = 0;
  localparam int F_BCL = 1;
  localparam int F_WRITE_COLLISION_FLAG = 2;
  localparam int F_OVF = 3;
  // baud generator and bit counts
  localparam int BAUD_W = 7;
  localparam logic [BAUD_W-1:0] BAUD_RESET = 7'h09;
  localparam logic [3:0] LAST_RX_BIT = 4'h7;
  localparam logic [3:0] ACK_BIT = 4'h8;
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // sequencer states
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_SWAIT = 4'h1,
    ST_SHOLD = 4'h2,
    ST_BLO = 4'h3,
    ST_BHW = 4'h4,
    ST_BHI = 4'h5,
    ST_ALO = 4'h6,
    ST_AHW = 4'h7,
    ST_AHI = 4'h8,
    ST_AEND = 4'h9,
    ST_PSDA = 4'hA,
    ST_PLO = 4'hB,
    ST_PHW = 4'hC,
    ST_PHI = 4'hD,
    ST_PEND = 4'hE
  } i2cm_state_t;
endpackage

//--- logic/i2cm_baud.sv
`timescale 1ns/1ps
module i2cm_baud import i2cm_pkg::*; #(
  parameter int W = BAUD_W
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // control
  input wire logic load_in,
  input wire logic run_in,
  input wire logic [W-1:0] reload_in,
  // status
  output logic expire_out
);
  logic [W-1:0] cnt;

  // loads, counts down one per tick and rests at zero
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cnt <= '0;
    end else if (load_in) begin
      cnt <= reload_in;
    end else if (run_in && cnt != '0) begin
      cnt <= cnt - 1'b1;
    end
  end

  // timeout seen only while running and not being reloaded
  assign expire_out = run_in && !load_in && cnt == '0;
endmodule // i2cm_baud

//--- logic/i2cm_master.sv
`timescale 1ns/1ps
// Functional notes
// - setting receive enable starts master reception of one byte
// - receive enable is ignored unless the sequencer is idle
// - each baud rollover toggles the clock; data bits shift into the register
// - after eighth fall: clear enable, load buffer, set full and interrupt, idle
// - reading the data buffer clears buffer full
// - byte arriving while buffer full sets overflow
// - data write during receive, ack or stop is dropped and sets write collision
// - ack enable drives the clock low and puts ack data on the data line
// - ack data comes from the bit in the same write as ack enable; data line follows that bit
// - ack: release clock, wait high, count, hold low one period, then idle
// - stop enable drives data low; once seen low, reload and count
// - release clock, then data; data and clock high end stop, set stop flag
// - released clock pauses the generator until seen high, then reloads
// - released data seen low while clock high, on a transmitted data bit or in the ack sequence, is a bus collision
// - collision in transmit halts, clears full, releases lines, buffer writable
// - collision in a sequence aborts it, releases lines, clears enables
// - bus monitor keeps watching; a stop condition sets the interrupt flag
// - a new data write after collision transmits from the first bit
// - start with either line already low aborts with a collision
// - start: count with data high; clock low meanwhile is a collision
// - start: early data low restarts count; then drive clock low at end
// - generator reloads from the low seven baud bits and stops at zero
module i2cm_master import i2cm_pkg::*; (
  // clock and reset
  input wire logic CLK_SYS_IN,
  input wire logic RST_IN,
  // register bus write channels
  input wire logic [7:0] AWADDR_IN,
  input wire logic AWVALID_IN,
  output logic AWREADY_OUT,
  input wire logic [31:0] WDATA_IN,
  input wire logic [3:0] WSTRB_IN,
  input wire logic WVALID_IN,
  output logic WREADY_OUT,
  output logic [1:0] BRESP_OUT,
  output logic BVALID_OUT,
  input wire logic BREADY_IN,
  // register bus read channels
  input wire logic [7:0] ARADDR_IN,
  input wire logic ARVALID_IN,
  output logic ARREADY_OUT,
  output logic [31:0] RDATA_OUT,
  output logic [1:0] RRESP_OUT,
  output logic RVALID_OUT,
  input wire logic RREADY_IN,
  // two-wire bus pins
  input wire logic SCL_IN,
  output logic SCL_OUT,
  output logic SCL_OE_OUT,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE_OUT
);
  i2cm_state_t state;
  logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
  logic aw_full, w_full, wr_go;
  logic [7:0] waddr;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_ctrl, wr_data, wr_baud, wr_flag, rd_data, data_ok;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic en_start, en_stop, en_recv, en_ack, ack_data, ack_stat, tx_mode;
  logic [BAUD_W-1:0] baud;
  logic [7:0] shift, data_buf;
  logic [3:0] bit_cnt;
  logic bg_load, bg_run, bg_expire;
  logic ev_rx, ev_tx, ev_stop, ev_coll, coll_now;
  logic bf, ovf, write_collision_flag, sif, bcl, start_det, stop_det, bus_start, bus_stop;

  // line synchronisers, third stage only for edge finding
  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      {scl_m, scl_s, scl_d} <= 3'h7;
      {sda_m, sda_s, sda_d} <= 3'h7;
    end else begin
      scl_m <= SCL_IN;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= SDA_IN;
      sda_s <= sda_m;
      sda_d <= sda_s;
    end
  end

  // open-drain pads only ever pull low
  always_ff @(posedge CLK_SYS_IN) begin
    SCL_OUT <= 1'b0;
    SDA_OUT <= 1'b0;
  end

  // write channels: address and data taken in either order
  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      AWREADY_OUT <= 1'b1;
      WREADY_OUT <= 1'b1;
      BVALID_OUT <= 1'b0;
      BRESP_OUT <= RESP_OKAY;
      waddr <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else begin
      if (AWVALID_IN && AWREADY_OUT) begin
        aw_full <= 1'b1;
        waddr <= AWADDR_IN;
        AWREADY_OUT <= 1'b0;
      end
      if (WVALID_IN && WREADY_OUT) begin
        w_full <= 1'b1;
        wdata_q <= WDATA_IN;
        wstrb_q <= WSTRB_IN;
        WREADY_OUT <= 1'b0;
      end
      if (wr_go) begin
        BVALID_OUT <= 1'b1;
        BRESP_OUT <= (waddr == ADDR_CTRL2 || waddr == ADDR_STAT || waddr == ADDR_DATA ||
                      waddr == ADDR_BAUD || waddr == ADDR_FLAG) ? RESP_OKAY : RESP_SLVERR;
      end
      if (BVALID_OUT && BREADY_IN) begin
        BVALID_OUT <= 1'b0;
        aw_full <= 1'b0;
        w_full <= 1'b0;
        AWREADY_OUT <= 1'b1;
        WREADY_OUT <= 1'b1;
      end
    end
  end

  // write strobes, low byte lane carries every register
  assign wr_go = aw_full && w_full && !BVALID_OUT;
  assign wr_ctrl = wr_go && wstrb_q[0] && waddr == ADDR_CTRL2;
  assign wr_data = wr_go && wstrb_q[0] && waddr == ADDR_DATA;
  assign wr_baud = wr_go && wstrb_q[0] && waddr == ADDR_BAUD;
  assign wr_flag = wr_go && wstrb_q[0] && waddr == ADDR_FLAG;
  assign rd_data = ARVALID_IN && ARREADY_OUT && ARADDR_IN == ADDR_DATA;
  assign data_ok = state == ST_IDLE;

  // read mux, unmapped addresses answer zero with an error
  always_comb begin
    next_rdata = '0;
    next_rresp = RESP_OKAY;
    case (ARADDR_IN)
      ADDR_CTRL2: next_rdata[7:0] = {1'b0, ack_stat, ack_data, en_ack, en_recv, en_stop,
                                     1'b0, en_start};
      ADDR_STAT: next_rdata[7:0] = {3'h0, stop_det, start_det, 2'h0, bf};
      ADDR_DATA: next_rdata[7:0] = data_buf;
      ADDR_BAUD: next_rdata[BAUD_W-1:0] = baud;
      ADDR_FLAG: next_rdata[7:0] = {4'h0, ovf, write_collision_flag, bcl, sif};
      default: next_rresp = RESP_SLVERR;
    endcase
  end

  // read channels
  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      ARREADY_OUT <= 1'b1;
      RVALID_OUT <= 1'b0;
      RDATA_OUT <= '0;
      RRESP_OUT <= RESP_OKAY;
    end else if (ARVALID_IN && ARREADY_OUT) begin
      ARREADY_OUT <= 1'b0;
      RVALID_OUT <= 1'b1;
      RDATA_OUT <= next_rdata;
      RRESP_OUT <= next_rresp;
    end else if (RVALID_OUT && RREADY_IN) begin
      RVALID_OUT <= 1'b0;
      ARREADY_OUT <= 1'b1;
    end
  end

  // configuration held by software
  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      baud <= BAUD_RESET;
      ack_data <= 1'b0;
    end else begin
      if (wr_baud) baud <= wdata_q[BAUD_W-1:0];
      if (wr_ctrl) ack_data <= wdata_q[B_ACK_DATA_VALUE];
    end
  end

  i2cm_baud #(.W(BAUD_W)) u_baud (
    .clk_in(CLK_SYS_IN),
    .rst_in(RST_IN),
    .load_in(bg_load),
    .run_in(bg_run),
    .reload_in(baud),
    .expire_out(bg_expire)
  );

  // collisions: start on a busy bus, lost data one, clock stolen
  always_comb begin
    coll_now = 1'b0;
    case (state)
      ST_IDLE: coll_now = wr_ctrl && wdata_q[B_START] && (!scl_s || !sda_s);
      ST_SWAIT: coll_now = !scl_s && sda_s;
      ST_BHI: coll_now = tx_mode && bit_cnt != ACK_BIT && !SDA_OE_OUT && !sda_s;
      ST_AHI: coll_now = !SDA_OE_OUT && !sda_s;
      ST_PHI: coll_now = !scl_s;
      default: coll_now = 1'b0;
    endcase
  end

  // bit sequencer, pin drives and command enables
  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      state <= ST_IDLE;
      SCL_OE_OUT <= 1'b0;
      SDA_OE_OUT <= 1'b0;
      {en_start, en_stop, en_recv, en_ack} <= 4'h0;
      {bg_load, bg_run, tx_mode, ack_stat} <= 4'h0;
      {ev_rx, ev_tx, ev_stop, ev_coll} <= 4'h0;
      shift <= '0;
      bit_cnt <= '0;
    end else begin
      bg_load <= 1'b0;
      {ev_rx, ev_tx, ev_stop, ev_coll} <= 4'h0;
      case (state)
        ST_IDLE: begin
          bg_run <= 1'b0;
          if (wr_ctrl && wdata_q[B_START]) begin
            en_start <= 1'b1;
            {bg_load, bg_run} <= 2'h3;
            state <= ST_SWAIT;
          end else if (wr_ctrl && wdata_q[B_STOP]) begin
            en_stop <= 1'b1;
            SCL_OE_OUT <= 1'b1;
            SDA_OE_OUT <= 1'b1;
            state <= ST_PSDA;
          end else if (wr_ctrl && wdata_q[B_RECV]) begin
            en_recv <= 1'b1;
            tx_mode <= 1'b0;
            bit_cnt <= '0;
            SCL_OE_OUT <= 1'b1;
            SDA_OE_OUT <= 1'b0;
            {bg_load, bg_run} <= 2'h3;
            state <= ST_BLO;
          end else if (wr_ctrl && wdata_q[B_ACK_SEQUENCE_ENABLE]) begin
            en_ack <= 1'b1;
            SCL_OE_OUT <= 1'b1;
            SDA_OE_OUT <= !wdata_q[B_ACK_DATA_VALUE];
            {bg_load, bg_run} <= 2'h3;
            state <= ST_ALO;
          end else if (wr_data) begin
            tx_mode <= 1'b1;
            shift <= wdata_q[7:0];
            bit_cnt <= '0;
            SCL_OE_OUT <= 1'b1;
            SDA_OE_OUT <= !wdata_q[7];
            {bg_load, bg_run} <= 2'h3;
            state <= ST_BLO;
          end
        end
        ST_SWAIT: begin
          if (bg_expire || !sda_s) begin
            SDA_OE_OUT <= 1'b1;
            bg_load <= 1'b1;
            state <= ST_SHOLD;
          end
        end
        ST_SHOLD: begin
          if (bg_expire) begin
            SCL_OE_OUT <= 1'b1;
            en_start <= 1'b0;
            bg_run <= 1'b0;
            state <= ST_IDLE;
          end
        end
        ST_BLO: begin
          if (bg_expire) begin
            SCL_OE_OUT <= 1'b0;
            bg_run <= 1'b0;
            state <= ST_BHW;
          end
        end
        ST_BHW: begin
          if (scl_s) begin
            {bg_load, bg_run} <= 2'h3;
            shift <= {shift[6:0], sda_s};
            if (bit_cnt == ACK_BIT) ack_stat <= sda_s;
            state <= ST_BHI;
          end
        end
        ST_BHI: begin
          if (bg_expire) begin
            SCL_OE_OUT <= 1'b1;
            bit_cnt <= bit_cnt + 4'h1;
            bg_load <= 1'b1;
            if (!tx_mode && bit_cnt == LAST_RX_BIT) begin
              en_recv <= 1'b0;
              bg_run <= 1'b0;
              ev_rx <= 1'b1;
              state <= ST_IDLE;
            end else if (tx_mode && bit_cnt == ACK_BIT) begin
              bg_run <= 1'b0;
              ev_tx <= 1'b1;
              state <= ST_IDLE;
            end else begin
              SDA_OE_OUT <= tx_mode && bit_cnt != LAST_RX_BIT && !shift[7];
              state <= ST_BLO;
            end
          end
        end
        ST_ALO: begin
          if (bg_expire) begin
            SCL_OE_OUT <= 1'b0;
            bg_run <= 1'b0;
            state <= ST_AHW;
          end
        end
        ST_AHW: begin
          if (scl_s) begin
            {bg_load, bg_run} <= 2'h3;
            state <= ST_AHI;
          end
        end
        ST_AHI: begin
          if (bg_expire) begin
            SCL_OE_OUT <= 1'b1;
            bg_load <= 1'b1;
            state <= ST_AEND;
          end
        end
        ST_AEND: begin
          if (bg_expire) begin
            en_ack <= 1'b0;
            SDA_OE_OUT <= 1'b0;
            bg_run <= 1'b0;
            state <= ST_IDLE;
          end
        end
        ST_PSDA: begin
          if (!sda_s) begin
            {bg_load, bg_run} <= 2'h3;
            state <= ST_PLO;
          end
        end
        ST_PLO: begin
          if (bg_expire) begin
            SCL_OE_OUT <= 1'b0;
            bg_run <= 1'b0;
            state <= ST_PHW;
          end
        end
        ST_PHW: begin
          if (scl_s) begin
            {bg_load, bg_run} <= 2'h3;
            state <= ST_PHI;
          end
        end
        ST_PHI: begin
          if (bg_expire) begin
            SDA_OE_OUT <= 1'b0;
            bg_run <= 1'b0;
            state <= ST_PEND;
          end
        end
        ST_PEND: begin
          if (sda_s && scl_s) begin
            en_stop <= 1'b0;
            ev_stop <= 1'b1;
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
      // a collision overrides whatever step was taken
      if (coll_now) begin
        state <= ST_IDLE;
        SCL_OE_OUT <= 1'b0;
        SDA_OE_OUT <= 1'b0;
        {en_start, en_stop, en_recv, en_ack} <= 4'h0;
        {bg_load, bg_run} <= 2'h0;
        ev_coll <= 1'b1;
      end
    end
  end

  // bus monitor for start and stop conditions by any master
  assign bus_start = scl_s && scl_d && sda_d && !sda_s;
  assign bus_stop = scl_s && scl_d && !sda_d && sda_s;

  // data buffer and status flags, set wins over clear
  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      data_buf <= '0;
      {bf, ovf, write_collision_flag, sif, bcl, start_det, stop_det} <= 7'h00;
    end else begin
      if (ev_rx) data_buf <= shift;
      else if (wr_data && data_ok) data_buf <= wdata_q[7:0];
      if (rd_data || ev_tx || ev_coll) bf <= 1'b0;
      if (ev_rx || (wr_data && data_ok)) bf <= 1'b1;
      if (wr_flag && wdata_q[F_OVF]) ovf <= 1'b0;
      if (ev_rx && bf) ovf <= 1'b1;
      if (wr_flag && wdata_q[F_WRITE_COLLISION_FLAG]) write_collision_flag <= 1'b0;
      if (wr_data && !data_ok) write_collision_flag <= 1'b1;
      if (wr_flag && wdata_q[F_BCL]) bcl <= 1'b0;
      if (ev_coll) bcl <= 1'b1;
      if (wr_flag && wdata_q[F_SIF]) sif <= 1'b0;
      if (ev_rx || ev_tx || ev_stop || bus_stop || bus_start) sif <= 1'b1;
      if (bus_stop) start_det <= 1'b0;
      if (bus_start) start_det <= 1'b1;
      if (bus_start) stop_det <= 1'b0;
      if (bus_stop || ev_stop) stop_det <= 1'b1;
    end
  end

  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (RST_IN);

  sequence s_released;
    !SCL_OE_OUT && !SDA_OE_OUT && {en_start, en_stop, en_recv, en_ack} == 4'h0;
  endsequence
  sequence s_stop_done;
    stop_det && sif && !en_stop;
  endsequence

  a_recv_only_idle: assert property ($rose(en_recv) |-> $past(state) == ST_IDLE)
    else $error("receive began outside idle");
  a_rx_done_flags: assert property (ev_rx |-> ##1 (bf && sif && !en_recv))
    else $error("byte end did not raise full and interrupt");
  a_read_clears_bf: assert property (rd_data && !ev_rx |=> !bf)
    else $error("buffer read left full set");
  a_ovf_on_full: assert property (ev_rx && bf |=> ovf)
    else $error("overflow missed");
  a_write_collision_flag_keeps_buf: assert property (wr_data && !data_ok && !ev_rx |=>
      write_collision_flag && data_buf == $past(data_buf))
    else $error("busy write not discarded");
  a_ack_line_drive: assert property ($rose(en_ack) |->
      SCL_OE_OUT && SDA_OE_OUT == !ack_data)
    else $error("ack enable did not set lines");
  a_stop_ends: assert property (ev_stop |=> s_stop_done)
    else $error("stop end flags wrong");
  a_clock_pause: assert property (state == ST_BHW && !scl_s |=>
      state == ST_BHW && !bg_run)
    else $error("generator ran with clock held low");
  a_coll_release: assert property (coll_now |=> s_released ##1 bcl)
    else $error("collision did not release the bus");
  a_start_abort: assert property (state == ST_IDLE && wr_ctrl && wdata_q[B_START] &&
      (!scl_s || !sda_s)
      |=> state == ST_IDLE && !en_start ##1 bcl)
    else $error("start on low bus not aborted");
endmodule // i2cm_master

//--- test/i2cm_slave_model.sv
`timescale 1ns/1ps
// slave that returns one byte per load, msb first, and may stretch the clock
module i2cm_slave_model (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // bus level and byte control
  input wire logic scl_in,
  input wire logic load_in,
  input wire logic [7:0] byte_in,
  input wire logic [4:0] stretch_in,
  // line pull-downs
  output logic scl_oe_out,
  output logic sda_oe_out
);
  logic scl_q;
  logic [3:0] rises;
  logic [4:0] hold;
  logic [7:0] data;
  // next bit goes out after each clock fall, line released after eight bits
  always_ff @(posedge clk_in) begin
    scl_q <= scl_in;
    if (rst_in) begin
      rises <= 4'h8;
      sda_oe_out <= 1'b0;
    end else if (load_in) begin
      rises <= 4'h0;
      data <= byte_in;
      sda_oe_out <= ~byte_in[7];
    end else if (scl_q && !scl_in) begin
      sda_oe_out <= (rises < 4'h8) ? ~data[3'h7 - rises[2:0]] : 1'b0;
    end else if (!scl_q && scl_in && rises < 4'h8) begin
      rises <= rises + 4'h1;
    end
  end
  // clock held low for a while after each fall of a received bit
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      hold <= 5'h00;
    end else if (scl_q && !scl_in && rises < 4'h8) begin
      hold <= stretch_in;
    end else if (hold != 5'h00) begin
      hold <= hold - 5'h01;
    end
  end
  assign scl_oe_out = (hold != 5'h00);
endmodule // i2cm_slave_model

//--- test/test_i2c_master_rx_ack_stop_arbitration.sv
`timescale 1ns/1ps
module test_i2c_master_rx_ack_stop_arbitration;
  import i2cm_pkg::*;
  logic clk, rst, awvalid, wvalid, bready, arvalid, rready, load;
  logic awready, wready, bvalid, arready, rvalid, scl_oe, sda_oe;
  logic [7:0] awaddr, araddr, sbyte, b;
  logic [31:0] wdata, rdata, rv, r;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rr;
  logic [4:0] stretch;
  logic s_scl_oe, s_sda_oe, bench_scl, bench_sda, scl_w, sda_w, scl_p, sda_p;
  logic ack_mon, ack_data_value;
  int err_total, check_count, stops, n, seed;
  // wired-and bus lines with pull-up
  assign scl_w = ~(scl_oe | s_scl_oe | bench_scl);
  assign sda_w = ~(sda_oe | s_sda_oe | bench_sda);
  // system clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  i2cm_master dut (.CLK_SYS_IN(clk), .RST_IN(rst), .AWADDR_IN(awaddr), .AWVALID_IN(awvalid),
    .AWREADY_OUT(awready), .WDATA_IN(wdata), .WSTRB_IN(wstrb), .WVALID_IN(wvalid),
    .WREADY_OUT(wready), .BRESP_OUT(bresp), .BVALID_OUT(bvalid), .BREADY_IN(bready),
    .ARADDR_IN(araddr), .ARVALID_IN(arvalid), .ARREADY_OUT(arready), .RDATA_OUT(rdata),
    .RRESP_OUT(rresp), .RVALID_OUT(rvalid), .RREADY_IN(rready), .SCL_IN(scl_w),
    .SCL_OUT(), .SCL_OE_OUT(scl_oe), .SDA_IN(sda_w), .SDA_OUT(), .SDA_OE_OUT(sda_oe));
  i2cm_slave_model slave (.clk_in(clk), .rst_in(rst), .scl_in(scl_w), .load_in(load),
    .byte_in(sbyte), .stretch_in(stretch), .scl_oe_out(s_scl_oe), .sda_oe_out(s_sda_oe));
  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // register write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
  endtask
  // register read
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rv = rdata;
    rr = rresp;
    rready <= 1'b0;
  endtask
  // wait for a register bit to reach a value
  task automatic poll(input logic [7:0] a, input int bit_i, input logic v);
    for (int i = 0; i < 500; i++) begin
      rd(a);
      if (rv[bit_i] === v) return;
    end
    chk({31'h0, rv[bit_i]}, {31'h0, v});
  endtask
  // flag word expected in the event register
  function automatic logic [31:0] flg(input logic sif, bcl, write_collision_flag, ovf);
    logic [31:0] f;
    f = 32'h0;
    f[F_SIF] = sif;
    f[F_BCL] = bcl;
    f[F_WRITE_COLLISION_FLAG] = write_collision_flag;
    f[F_OVF] = ovf;
    return f;
  endfunction
  // arm the slave and start a byte reception
  task automatic recv(input logic [7:0] d, input logic [4:0] st);
    @(posedge clk);
    sbyte <= d;
    stretch <= st;
    load <= 1'b1;
    @(posedge clk);
    load <= 1'b0;
    wr(ADDR_CTRL2, 32'h08);
  endtask
  // bus watchers: stop conditions and acknowledge level
  always @(posedge clk) begin
    scl_p <= scl_w;
    sda_p <= sda_w;
    if (scl_p && scl_w && !sda_p && sda_w) stops <= stops + 1;
    if (ack_mon && !scl_p && scl_w) chk({31'h0, sda_oe}, {31'h0, ~ack_data_value});
  end
  // watchdog
  initial begin
    #800000;
    err_total++;
    tally_and_finish;
  end
  // main sequence
  initial begin
    seed = 32'h68AC6286;
    {awvalid, wvalid, bready, arvalid, rready, load, bench_scl, bench_sda} <= 8'h00;
    {awaddr, araddr, sbyte, wdata, stretch} <= 61'h0;
    {ack_mon, ack_data_value, scl_p, sda_p} <= 4'h3;
    wstrb <= 4'hF;
    rst <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd(ADDR_BAUD);
    chk(rv, {25'h0, BAUD_RESET});
    rd(8'h14);
    chk({30'h0, rr}, {30'h0, RESP_SLVERR});
    wr(ADDR_BAUD, 32'h02);
    rd(ADDR_STAT);
    chk(rv, 32'h0);
    wr(ADDR_CTRL2, 32'h01);
    poll(ADDR_CTRL2, B_START, 1'b0);
    wr(ADDR_FLAG, 32'h0F);
    // reception with a buffer write and a stop request while busy
    r = $random(seed);
    b = r[7:0];
    recv(b, 5'h00);
    wr(ADDR_DATA, 32'hA5);
    wr(ADDR_CTRL2, 32'h04);
    poll(ADDR_CTRL2, B_RECV, 1'b0);
    chk({31'h0, rv[B_STOP]}, 32'h0);
    rd(ADDR_FLAG);
    chk(rv, flg(1'b1, 1'b0, 1'b1, 1'b0));
    rd(ADDR_STAT);
    chk({31'h0, rv[S_BF]}, 32'h1);
    rd(ADDR_DATA);
    chk(rv, {24'h0, b});
    rd(ADDR_STAT);
    chk({31'h0, rv[S_BF]}, 32'h0);
    wr(ADDR_FLAG, 32'h0F);
    // stretched random bytes, every second one arrives unread
    for (int i = 0; i < 4; i++) begin
      r = $random(seed);
      recv(r[15:8], r[4:0]);
      poll(ADDR_CTRL2, B_RECV, 1'b0);
      rd(ADDR_FLAG);
      chk({31'h0, rv[F_OVF]}, {31'h0, i[0]});
      if (i[0]) begin
        rd(ADDR_DATA);
        wr(ADDR_FLAG, 32'h0F);
      end
    end
    // acknowledge sequence with both data values
    for (int k = 0; k < 2; k++) begin
      ack_data_value = k[0];
      wr(ADDR_CTRL2, {26'h0, k[0], 5'h00});
      ack_mon <= 1'b1;
      wr(ADDR_CTRL2, {26'h0, k[0], 5'h10});
      poll(ADDR_CTRL2, B_ACK_SEQUENCE_ENABLE, 1'b0);
      ack_mon <= 1'b0;
    end
    // stop sequence
    n = stops;
    wr(ADDR_CTRL2, 32'h04);
    poll(ADDR_CTRL2, B_STOP, 1'b0);
    chk(32'(stops), 32'(n + 1));
    rd(ADDR_STAT);
    chk({31'h0, rv[S_STOPD]}, 32'h1);
    rd(ADDR_FLAG);
    chk({31'h0, rv[F_SIF]}, 32'h1);
    // another master pulls data low while a one is sent
    wr(ADDR_FLAG, 32'h0F);
    wr(ADDR_CTRL2, 32'h01);
    poll(ADDR_CTRL2, B_START, 1'b0);
    bench_sda <= 1'b1;
    wr(ADDR_DATA, 32'hFF);
    poll(ADDR_FLAG, F_BCL, 1'b1);
    rd(ADDR_STAT);
    chk({31'h0, rv[S_BF]}, 32'h0);
    chk({30'h0, scl_oe, sda_oe}, 32'h0);
    wr(ADDR_FLAG, 32'h0F);
    bench_sda <= 1'b0;
    poll(ADDR_FLAG, F_SIF, 1'b1);
    // start refused while the clock is held low
    bench_scl <= 1'b1;
    wr(ADDR_CTRL2, 32'h01);
    poll(ADDR_FLAG, F_BCL, 1'b1);
    poll(ADDR_CTRL2, B_START, 1'b0);
    bench_scl <= 1'b0;
    tally_and_finish;
  end
endmodule // test_i2c_master_rx_ack_stop_arbitration
